/* hw/hpc_pkg.sv */
/*
 * Shared constants and types of the hibernation power-control block:
 * register offsets, control layout, interrupt bit positions, reset values.
 * Assumes a 32-bit register port with byte addresses, word aligned.
 */
package hpc_pkg;

    // register byte offsets
    localparam logic [9:0] OFS_CTRL   = 10'h000;
    localparam logic [9:0] OFS_COUNT  = 10'h004;
    localparam logic [9:0] OFS_MATCH0 = 10'h008;
    localparam logic [9:0] OFS_MATCH1 = 10'h00C;
    localparam logic [9:0] OFS_LOAD   = 10'h010;
    localparam logic [9:0] OFS_TRIM   = 10'h014;
    localparam logic [9:0] OFS_IMASK  = 10'h018;
    localparam logic [9:0] OFS_RSTAT  = 10'h01C;
    localparam logic [9:0] OFS_MSTAT  = 10'h020;
    localparam logic [1:0] DATA_PAGE  = 2'h1;

    // interrupt / status bit positions
    localparam int IRQ_LOWBAT = 0;
    localparam int IRQ_MATCH0 = 1;
    localparam int IRQ_MATCH1 = 2;
    localparam int IRQ_WAKE   = 3;
    localparam int NIRQ       = 4;

    // reset values and timing counts
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [31:0] MATCH_RST   = 32'hFFFFFFFF;
    localparam logic [15:0] PREDIV_NOM  = 16'h7FFF;
    localparam logic [6:0]  XTAL_DIV_M1 = 7'h7F;
    localparam logic [5:0]  TRIM_SEC    = 6'h3F;

    typedef enum logic {HPC_RUN, HPC_SLEEP} hpc_state_e;

    typedef struct packed {
        logic vabort;
        logic slow_clock_enable;
        logic lowbat_en;
        logic rtc_wake_en;
        logic pin_wake_en;
        logic slow_clock_type_select;
        logic rtc_en;
        logic sleep_request_bit;
    } hpc_ctrl_s;

endpackage

/* hw/hpc_top.sv */
/*
 * Hibernation power control: open-drain power-off request, wake logic,
 * 32-bit RTC with predivider and trim, two match values, retained words,
 * low-battery detection and a masked interrupt.
 * Assumes all inputs but OSC_IN_I synchronous to CORE_CLK_I and the oscillator input
 * far slower than CORE_CLK_I.
 */
//
// What this block does
// (RQ1) Drive power-off low while hibernating
// (RQ2) Wake on wake pin or RTC match
// (RQ3) Detect low battery, optionally refuse hibernate
// (RQ4) 32-bit RTC counter on slow clock
// (RQ5) Two 32-bit match values against RTC
// (RQ6) Sixty-four retained 32-bit words
// (RQ7) Maskable match, wake, low-battery interrupts
// (RQ8) Software spaces writes to slow registers
// (RQ9) Back-to-back reads need no spacing
// (RQ10) System always supplies the slow clock
// (RQ11) Crystal input divided by 128
// (RQ12) Slow clock only after enable bit
// (RQ13) Type select: 0 crystal, 1 oscillator
// (RQ14) Software waits for crystal to settle
// (RQ15) Wake releases power-off, supply returns
// (RQ16) Predivider makes one-second RTC tick
// (RQ17) Request bit starts hibernation
// (RQ18) Slow clock crosses safely into core
`timescale 1ns/1ps

module hpc_top
    import hpc_pkg::*;
#(
    parameter int DATA_WORDS = 64
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic [9:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    input  wire logic        OSC_IN_I,
    output logic             OSC_OUT_O,
    input  wire logic        WAKE_N_I,
    input  wire logic        LOW_BATT_I,
    output logic             POWER_OFF_REQUEST_N_O,
    output logic             POWER_OFF_REQUEST_N_OE_O,
    output logic             IRQ_O
);

    ////////////////////////////////////////////////////////////////////
    // state
    hpc_state_e      state;
    hpc_state_e      next_state;
    hpc_ctrl_s       ctrl;
    logic [31:0]     rtc;
    logic [31:0]     match0;
    logic [31:0]     match1;
    logic [15:0]     trim;
    logic [15:0]     prediv;
    logic [5:0]      sec_cnt;
    logic [6:0]      div_cnt;
    logic [NIRQ-1:0] ris;
    logic [NIRQ-1:0] imask;
    logic [31:0]     mem [DATA_WORDS];
    logic            osc_s1;
    logic            osc_s2;
    logic            osc_s3;
    logic            wake_d;
    logic            lowbat_d;
    logic            eq0_d;
    logic            eq1_d;

    ////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_ctrl   = WR_I && ADDR_I == OFS_CTRL;
    wire wr_match0 = WR_I && ADDR_I == OFS_MATCH0;
    wire wr_match1 = WR_I && ADDR_I == OFS_MATCH1;
    wire wr_load   = WR_I && ADDR_I == OFS_LOAD;
    wire wr_trim   = WR_I && ADDR_I == OFS_TRIM;
    wire wr_imask  = WR_I && ADDR_I == OFS_IMASK;
    wire wr_rstat  = WR_I && ADDR_I == OFS_RSTAT;
    wire is_data   = ADDR_I[9:8] == DATA_PAGE;
    wire wr_data   = WR_I && is_data;
    wire [5:0] data_idx = ADDR_I[7:2];
    wire [NIRQ-1:0] mis = ris & imask;

    // reads are single cycle with no spacing needed [RQ9]
    wire [31:0] rd_mux =
        is_data                ? mem[data_idx] :
        ADDR_I == OFS_CTRL     ? {24'h000000, ctrl} :
        ADDR_I == OFS_COUNT    ? rtc :
        ADDR_I == OFS_MATCH0   ? match0 :
        ADDR_I == OFS_MATCH1   ? match1 :
        ADDR_I == OFS_LOAD     ? rtc :
        ADDR_I == OFS_TRIM     ? {16'h0000, trim} :
        ADDR_I == OFS_IMASK    ? {28'h0000000, imask} :
        ADDR_I == OFS_RSTAT    ? {28'h0000000, ris} :
        ADDR_I == OFS_MSTAT    ? {28'h0000000, mis} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////
    // slow clock: oscillator sampled into the core domain
    // s1 feeds s2 only; edge detection looks at s2/s3 [RQ18]
    wire osc_edge  = osc_s2 && !osc_s3;
    // crystal path counts 128 edges per tick, oscillator ticks each edge
    wire slow_tick = ctrl.slow_clock_enable && osc_edge &&               // [RQ12]
                     (ctrl.slow_clock_type_select || div_cnt == XTAL_DIV_M1); // [RQ11] [RQ13]

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= OSC_IN_I;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            div_cnt <= 7'h00;
        end else if (!ctrl.slow_clock_enable || ctrl.slow_clock_type_select) begin
            div_cnt <= 7'h00;
        end else if (osc_edge) begin
            div_cnt <= div_cnt + 7'h01;                                 // [RQ11]
        end
    end

    // crude inverting drive for a crystal; idle low otherwise
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            OSC_OUT_O <= 1'b0;
        end else begin
            OSC_OUT_O <= ctrl.slow_clock_enable && !ctrl.slow_clock_type_select && !osc_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // predivider and RTC; trim replaces nominal once every 64 seconds
    wire        sec_tick   = slow_tick && ctrl.rtc_en && prediv == 16'h0000;
    wire [15:0] prediv_top = (sec_cnt == TRIM_SEC) ? trim : PREDIV_NOM;

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            prediv  <= PREDIV_NOM;
            sec_cnt <= 6'h00;
        end else if (slow_tick && ctrl.rtc_en) begin
            prediv  <= (prediv == 16'h0000) ? prediv_top : prediv - 16'h0001; // [RQ16]
            sec_cnt <= sec_tick ? sec_cnt + 6'h01 : sec_cnt;
        end
    end

    // software load wins over the tick
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rtc <= 32'h00000000;
        end else if (wr_load) begin
            rtc <= WDATA_I;
        end else if (sec_tick) begin
            rtc <= rtc + 32'h00000001;                                  // [RQ4]
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            match0 <= MATCH_RST;
            match1 <= MATCH_RST;
            trim   <= PREDIV_NOM;
            imask  <= '0;
        end else begin
            if (wr_match0) match0 <= WDATA_I;                           // [RQ5]
            if (wr_match1) match1 <= WDATA_I;                           // [RQ5]
            if (wr_trim)   trim   <= WDATA_I[15:0];
            if (wr_imask)  imask  <= WDATA_I[NIRQ-1:0];                 // [RQ7]
        end
    end

    // retained words: no reset so content survives a system reset
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_data) begin
            mem[data_idx] <= WDATA_I;                                   // [RQ6]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // events
    wire eq0       = rtc == match0;
    wire eq1       = rtc == match1;
    wire ev_match0 = ctrl.rtc_en && eq0 && !eq0_d;                      // [RQ5]
    wire ev_match1 = ctrl.rtc_en && eq1 && !eq1_d;                      // [RQ5]
    wire ev_wake   = !WAKE_N_I && wake_d;
    // battery is not measured while hibernating
    wire lowbat    = ctrl.lowbat_en && LOW_BATT_I && state == HPC_RUN;  // [RQ3]
    wire ev_lowbat = lowbat && !lowbat_d;
    wire [NIRQ-1:0] ev_vec = {ev_wake, ev_match1, ev_match0, ev_lowbat};

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wake_d   <= 1'b1;
            lowbat_d <= 1'b0;
            eq0_d    <= 1'b0;
            eq1_d    <= 1'b0;
        end else begin
            wake_d   <= WAKE_N_I;
            lowbat_d <= lowbat;
            eq0_d    <= eq0;
            eq1_d    <= eq1;
        end
    end

    // write-one-to-clear; a same-cycle event keeps its bit
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ris <= '0;
        end else begin
            ris <= (ris & ~(wr_rstat ? WDATA_I[NIRQ-1:0] : '0)) | ev_vec; // [RQ7]
        end
    end

    assign IRQ_O = |mis;                                                // [RQ7]

    ////////////////////////////////////////////////////////////////////
    // hibernate sequencing
    wire abort    = ctrl.vabort && lowbat;                              // [RQ3]
    wire go_sleep = wr_ctrl && WDATA_I[0] && !abort;                    // [RQ17]
    wire wake_now = (ctrl.pin_wake_en && !WAKE_N_I) ||
                    (ctrl.rtc_wake_en && (ev_match0 || ev_match1));     // [RQ2]

    always_comb begin
        next_state = state;
        case (state)
            HPC_RUN: begin
                if (go_sleep) next_state = HPC_SLEEP;                   // [RQ17]
            end
            HPC_SLEEP: begin
                if (wake_now) next_state = HPC_RUN;                     // [RQ2] [RQ15]
            end
            default: next_state = HPC_RUN;
        endcase
    end

    // request bit clears as hibernation ends; a control write in that cycle wins over the clear
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state <= HPC_RUN;
            ctrl  <= CTRL_RST;
        end else begin
            state <= next_state;
            if (wr_ctrl) begin
                ctrl <= {WDATA_I[7:1], go_sleep};
            end else if (next_state == HPC_RUN) begin
                ctrl.sleep_request_bit <= 1'b0;
            end
        end
    end

    // open drain: pull low while hibernating, released on wake
    assign POWER_OFF_REQUEST_N_O    = 1'b0;
    assign POWER_OFF_REQUEST_N_OE_O = state == HPC_SLEEP;              // [RQ1] [RQ15]

    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            RDATA_O <= 32'h00000000;
        end else if (RD_I) begin
            RDATA_O <= rd_mux;                                          // [RQ9]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    // software leaves one idle cycle after a retained write
    sequence s_data_wr;
        WR_I && is_data ##1 !WR_I;
    endsequence

    sequence s_rd_back;
        RD_I && !WR_I && ADDR_I == $past(ADDR_I, 2);
    endsequence

    property p_sleep_entry;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        state == HPC_RUN && wr_ctrl && WDATA_I[0] && !abort |=> POWER_OFF_REQUEST_N_OE_O;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no power-off"); // [RQ1]

    property p_pin_wake;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        state == HPC_SLEEP && ctrl.pin_wake_en && !WAKE_N_I |=> !POWER_OFF_REQUEST_N_OE_O;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("wake pin ignored"); // [RQ2]

    property p_abort;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        state == HPC_RUN && wr_ctrl && ctrl.vabort && ctrl.lowbat_en && LOW_BATT_I
        |=> !POWER_OFF_REQUEST_N_OE_O;
    endproperty
    a_abort: assert property (p_abort) else $error("slept on low battery"); // [RQ3]

    property p_rtc_inc;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        sec_tick && !wr_load |=> rtc == $past(rtc) + 32'h00000001;
    endproperty
    a_rtc_inc: assert property (p_rtc_inc) else $error("rtc missed tick"); // [RQ4]

    property p_match_flag;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        ctrl.rtc_en && $rose(eq0) |=> ris[IRQ_MATCH0];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match not flagged"); // [RQ5]

    property p_retain;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        s_data_wr ##1 s_rd_back |=> RDATA_O == $past(WDATA_I, 3);
    endproperty
    a_retain: assert property (p_retain) else $error("retained word lost"); // [RQ6]

    property p_irq;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        ev_wake && imask[IRQ_WAKE] |=> IRQ_O;
    endproperty
    a_irq: assert property (p_irq) else $error("wake irq missing"); // [RQ7]

    property p_rd_count;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        RD_I && ADDR_I == OFS_COUNT |=> RDATA_O == $past(rtc);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("bad count read"); // [RQ9]

    property p_div128;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        slow_tick && !ctrl.slow_clock_type_select && !wr_ctrl |=> div_cnt == 7'h00;
    endproperty
    a_div128: assert property (p_div128) else $error("divider off"); // [RQ11]

    property p_clk_gate;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        !ctrl.slow_clock_enable |-> !slow_tick;
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("tick while disabled"); // [RQ12]

    property p_prediv;
        @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        sec_tick |=> prediv == $past(prediv_top);
    endproperty
    a_prediv: assert property (p_prediv) else $error("predivider reload"); // [RQ16]

endmodule

/* verif/hpc_far_model.sv */
/*
 * Far side of the hibernation block: regulator, wake source, slow oscillator.
 * Assumes the bench commands the wake source; the oscillator runs free.
 */
`timescale 1ns/1ps

module hpc_far_model #(
    parameter int OSC_HALF_NS = 40
) (
    input  wire logic off_n_i,
    input  wire logic off_oe_i,
    input  wire logic wake_cmd_i,
    output logic      osc_o,
    output logic      wake_n_o,
    output logic      supply_on_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic pin;

    // pull-up on the power-off line, regulator runs while it is high
    assign pin         = off_oe_i ? off_n_i : 1'b1;
    assign supply_on_o = pin;
    // weak pull-up keeps wake idle high
    assign wake_n_o    = wake_cmd_i ? 1'b0 : 1'b1;

    // free running: the block needs its clock even with the rtc unused
    initial begin
        osc_o = 1'b0;
        forever #(OSC_HALF_NS) osc_o = ~osc_o;
    end
endmodule

/* verif/hpc_tb_top.sv */
/*
 * Self-checking bench of the hibernation power-control block.
 * Assumes hpc_pkg offsets and the far-side model hpc_far_model.
 */
`timescale 1ns/1ps

module hibernation_power_control_tb_top;
    import hpc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic        core_clk;
    logic        sys_rst;
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        osc_in;
    logic        osc_out;
    logic        wake_n;
    logic        low_batt;
    logic        off_n;
    logic        off_oe;
    logic        irq;
    logic        wake_cmd;
    logic        supply_on;
    int          error_cnt;
    int          checks_done;
    int          seed;
    int          toggles;
    logic [31:0] mdl [int];
    logic [31:0] v;
    logic [31:0] rst_tab [9] = '{32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0,
                                 32'h7FFF, 32'h0, 32'h0, 32'h0};

    hpc_top dut_u (.CORE_CLK_I(core_clk), .SYS_RST_I(sys_rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .OSC_IN_I(osc_in),
        .OSC_OUT_O(osc_out), .WAKE_N_I(wake_n), .LOW_BATT_I(low_batt),
        .POWER_OFF_REQUEST_N_O(off_n), .POWER_OFF_REQUEST_N_OE_O(off_oe), .IRQ_O(irq));

    // fast slow clock: one tick per two core cycles keeps a full second in the run
    hpc_far_model #(.OSC_HALF_NS(10)) far_u (.off_n_i(off_n), .off_oe_i(off_oe),
        .wake_cmd_i(wake_cmd),
        .osc_o(osc_in), .wake_n_o(wake_n), .supply_on_o(supply_on));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(osc_out) toggles++;

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t word got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic r, input logic [9:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= d;
    endtask

    // idle cycle after each write keeps the slow-register gap
    task automatic wreg(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
        mdl[a] = d;
        #1;
    endtask

    task automatic rreg(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, 1'b1, a, 32'h0);
        bus(1'b0, 1'b0, a, 32'h0);
        #1;
        chk32(rdata, exp);
    endtask

    task automatic wait_oe_low();
        for (int n = 0; n < 4 && off_oe !== 1'b0; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk1(off_oe, 1'b0);
        chk1(supply_on, 1'b1);
    endtask

    function automatic logic [9:0] dw(input int i);
        return 10'(256 + 4 * i);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        // tests take about 67000 cycles, most of it one rtc second
        #900000;
        error_cnt++;
        final_report();
    end

    initial begin
        {wr, rd, addr, wdata, low_batt, wake_cmd} = '0;
        {error_cnt, checks_done, toggles} = '0;
        seed = 40;
        sys_rst = 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk1(off_oe, 1'b0);
        chk1(irq, 1'b0);
        for (int i = 0; i < 9; i++) rreg(10'(4 * i), rst_tab[i]);
        wreg(OFS_COUNT, 32'h1234);
        rreg(OFS_COUNT, 32'h0);
        wreg(10'h3FC, 32'h55);
        rreg(10'h3FC, 32'h0);
        $display("test reset values done");

        for (int i = 0; i < 64; i++) wreg(dw(i), $random(seed));
        for (int i = 0; i < 64; i++) begin
            bus(1'b0, 1'b1, dw(i), 32'h0);
            #1;
            if (i > 0) chk32(rdata, mdl[dw(i - 1)]);
        end
        bus(1'b0, 1'b0, 10'h0, 32'h0);
        #1;
        chk32(rdata, mdl[dw(63)]);
        wreg(dw(9), 32'hA5A5F00F);
        rreg(dw(9), 32'hA5A5F00F);
        $display("test retained words done");

        toggles = 0;
        repeat (40) @(posedge core_clk);
        chk1(toggles == 0, 1'b1);
        wreg(OFS_CTRL, 32'h40);
        toggles = 0;
        // long enough for the crystal to settle and one divide-by-128 wrap
        repeat (300) @(posedge core_clk);
        chk1(toggles > 0, 1'b1);
        wreg(OFS_CTRL, 32'h44);
        repeat (4) @(posedge core_clk);
        toggles = 0;
        repeat (40) @(posedge core_clk);
        chk1(toggles == 0, 1'b1);
        $display("test clock source done");

        wreg(OFS_IMASK, 32'h8);
        wreg(OFS_CTRL, 32'h4D);
        chk1(off_oe, 1'b1);
        repeat (20) @(posedge core_clk);
        #1;
        chk1(supply_on, 1'b0);
        wake_cmd <= 1'b1;
        wait_oe_low();
        chk1(irq, 1'b1);
        wake_cmd <= 1'b0;
        rreg(OFS_CTRL, 32'h4C);
        rreg(OFS_RSTAT, 32'h8);
        wreg(OFS_RSTAT, 32'h8);
        rreg(OFS_RSTAT, 32'h0);
        $display("test pin wake done");

        low_batt <= 1'b1;
        // refusal follows the configuration already held, so set it first
        wreg(OFS_CTRL, 32'hEC);
        wreg(OFS_CTRL, 32'hED);
        repeat (4) @(posedge core_clk);
        #1;
        chk1(off_oe, 1'b0);
        rreg(OFS_CTRL, 32'hEC);
        rreg(OFS_RSTAT, 32'h1);
        chk1(irq, 1'b0);
        wreg(OFS_IMASK, 32'h1);
        chk1(irq, 1'b1);
        rreg(OFS_MSTAT, 32'h1);
        low_batt <= 1'b0;
        wreg(OFS_RSTAT, 32'h1);
        chk1(irq, 1'b0);
        $display("test low battery done");

        v = {1'b0, 31'($random(seed))};
        wreg(OFS_MATCH1, v);
        rreg(OFS_MATCH1, v);
        wreg(OFS_CTRL, 32'h56);
        wreg(OFS_CTRL, 32'h57);
        chk1(off_oe, 1'b1);
        wreg(OFS_LOAD, v);
        wait_oe_low();
        rreg(OFS_COUNT, v);
        rreg(OFS_RSTAT, 32'h4);
        chk1(irq, 1'b0);
        wreg(OFS_IMASK, 32'h4);
        chk1(irq, 1'b1);
        $display("test rtc match wake done");

        // first second ends 32768 slow ticks after rtc enable
        wreg(OFS_MATCH0, 32'h101);
        wreg(OFS_LOAD, 32'h100);
        repeat (60000) @(posedge core_clk);
        rreg(OFS_COUNT, 32'h100);
        repeat (6000) @(posedge core_clk);
        rreg(OFS_COUNT, 32'h101);
        rreg(OFS_RSTAT, 32'h6);
        chk1(irq, 1'b1);
        $display("test one-second tick done");
        final_report();
    end
endmodule
